// File: dv/eeam_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module eeam_asserts
    import eeam_pkg::*;
#(
    parameter int LOAD_CYC = 20
) (
    input wire logic link_clk,
    input wire logic link_rst,
    input wire logic scl,
    input wire logic sda_m_o,
    input wire logic sda_m_oe,
    input wire logic sda_d_o,
    input wire logic sda_d_oe,
    input wire logic sda
);
    logic prev_scl_q, prev_scl_d, prev_sda_q, prev_sda_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] byte_q, byte_d;
    logic [15:0] up_q, up_d;

    // cnt counts scl rises since the last start; 4'hF means no frame seen yet
    always_comb begin
        prev_scl_d = scl;
        prev_sda_d = sda;
        cnt_d = cnt_q;
        byte_d = byte_q;
        up_d = up_q;
        if (up_q != 16'hFFFF) begin
            up_d = up_q + 16'h1;
        end
        if (prev_sda_q && !sda && scl && prev_scl_q) begin
            cnt_d = 4'h0;
        end else if (scl && !prev_scl_q && cnt_q != 4'hF) begin
            cnt_d = cnt_q + 4'h1;
            if (cnt_q < 4'h8) begin
                byte_d = {byte_q[6:0], sda};
            end
        end
    end

    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            prev_scl_q <= 1'b1;
            prev_sda_q <= 1'b1;
            cnt_q <= 4'hF;
            byte_q <= 8'h00;
            up_q <= 16'h0000;
        end else begin
            prev_scl_q <= prev_scl_d;
            prev_sda_q <= prev_sda_d;
            cnt_q <= cnt_d;
            byte_q <= byte_d;
            up_q <= up_d;
        end
    end

    default clocking cb @(posedge link_clk);
    endclocking
    default disable iff (link_rst);

    a_master_low_drive: assert property (sda_m_o == 1'b0 && sda_d_o == 1'b0)
        else $error("open-drain data driven high");
    a_ack_scl_low: assert property ($changed(sda_d_oe) |-> !scl)
        else $error("device moved sda while scl high");
    a_ack_ninth_slot: assert property ($rose(sda_d_oe) |-> cnt_q == 4'h8)
        else $error("device ack outside the ninth clock");
    a_ack_type_code: assert property ($rose(sda_d_oe) |-> byte_q[7:4] == TYPE_CODE)
        else $error("device acked a foreign type code");
    a_ack_after_load: assert property ($rose(sda_d_oe) |-> up_q >= 16'(LOAD_CYC))
        else $error("device acked before the code load");
    a_ack_release: assert property ($rose(sda_d_oe) |-> ##[10:20] $fell(sda_d_oe))
        else $error("device ack not released after its slot");
    a_scl_high_width: assert property ($rose(scl) |-> scl[*6])
        else $error("scl high phase too short");
    a_frame_length: assert property ((scl && $rose(sda)) |-> cnt_q == 4'hA)
        else $error("stop not after address byte and ack");
endmodule
`default_nettype wire

// File: dv/test_eeprom_slave_address_match.sv
`timescale 1ns/1ps
`default_nettype none
module test_eeprom_slave_address_match;
    import eeam_pkg::*;
    logic clk, rst, m_ce, req, rw, dev_ce, sel_seen, mm_seen;
    logic [ADDR_BITS-1:0] addr;
    logic [7:0] mem_code;
    logic ready, done, acked, loaded, code_err, selected, read_sel, mismatch;
    logic [2:0] ref_code;
    int fails, num_checks;

    eeam_link_if i_eeam_link_if();
    eeam_master #(.LOAD_CYCLES(100)) i_eeam_master(.CLK(clk), .RST(rst), .CE(m_ce), .REQ(req), .ADDR(addr),
        .RW(rw), .READY(ready), .DONE(done), .ACKED(acked), .bus(i_eeam_link_if.master));
    eeam_device #(.LOAD_CYCLES(20)) i_eeam_device(.CE(dev_ce), .MEM_CODE(mem_code), .LOADED(loaded),
        .REF_CODE(ref_code), .CODE_ERR(code_err), .SELECTED(selected), .READ_SEL(read_sel),
        .MISMATCH(mismatch), .bus(i_eeam_link_if.device));
    eeam_asserts #(.LOAD_CYC(20)) i_eeam_asserts(.link_clk(i_eeam_link_if.link_clk),
        .link_rst(i_eeam_link_if.link_rst), .scl(i_eeam_link_if.scl), .sda_m_o(i_eeam_link_if.sda_m_o),
        .sda_m_oe(i_eeam_link_if.sda_m_oe), .sda_d_o(i_eeam_link_if.sda_d_o),
        .sda_d_oe(i_eeam_link_if.sda_d_oe), .sda(i_eeam_link_if.sda));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // mismatch pulses one link cycle wide and selected clears at the stop, so catch them where they stand
    always @(posedge i_eeam_link_if.link_clk) begin
        if (selected === 1'b1) sel_seen = 1'b1;
        if (mismatch === 1'b1) mm_seen = 1'b1;
    end

    task automatic wrap_up;
        if (fails == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            fails++;
        end
    endtask

    task automatic do_reset(input logic [7:0] code);
        @(negedge clk);
        rst = 1'b1;
        mem_code = code;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 400 && ready !== 1'b1; i++) @(negedge clk);
        chk("ready", 8'h01, {7'h00, ready});
    endtask

    task automatic send(input logic [6:0] a, input logic r, input logic exp_ack, input logic exp_mm);
        sel_seen = 1'b0;
        mm_seen = 1'b0;
        addr = a;
        rw = r;
        req = 1'b1;
        @(negedge clk);
        req = 1'b0;
        for (int i = 0; i < 500 && done !== 1'b1; i++) @(negedge clk);
        chk("done", 8'h01, {7'h00, done});
        // bus-free gap so the device sees the stop before the next start
        repeat (8) @(negedge clk);
        chk("acked", {7'h00, exp_ack}, {7'h00, acked});
        chk("selected", {7'h00, exp_ack}, {7'h00, sel_seen});
        chk("mismatch", {7'h00, exp_mm}, {7'h00, mm_seen});
    endtask

    initial begin
        rst = 1'b1;
        req = 1'b0;
        addr = '0;
        rw = 1'b0;
        m_ce = 1'b1;
        dev_ce = 1'b0;
        mem_code = 8'h03;
        sel_seen = 1'b0;
        mm_seen = 1'b0;
        fails = 0;
        num_checks = 0;
        do_reset(8'h03);
        send({TYPE_CODE, 3'h3}, 1'b0, 1'b0, 1'b0);
        chk("loaded", 8'h00, {7'h00, loaded});
        dev_ce = 1'b1;
        for (int i = 0; i < 200 && loaded !== 1'b1; i++) @(negedge clk);
        chk("loaded", 8'h01, {7'h00, loaded});
        chk("ref_code", 8'h03, {5'h00, ref_code});
        for (int c = 0; c < 8; c++) begin
            do_reset(8'(c));
            chk("ref_code", 8'(c), {5'h00, ref_code});
            chk("code_err", 8'h00, {7'h00, code_err});
            send({TYPE_CODE ^ (4'h1 << (c % 4)), 3'(c)}, 1'b0, 1'b0, 1'b1);
            send({TYPE_CODE, 3'(c) ^ (3'h1 << (c % 3))}, 1'b1, 1'b0, 1'b1);
            send({TYPE_CODE, 3'(c)}, c[0], 1'b1, 1'b0);
            chk("read_sel", 8'(c % 2), {7'h00, read_sel});
        end
        do_reset(8'h0D);
        chk("code_err", 8'h01, {7'h00, code_err});
        chk("ref_code", 8'h05, {5'h00, ref_code});
        send({TYPE_CODE, 3'h5}, 1'b1, 1'b1, 1'b0);
        wrap_up();
    end

    initial begin
        repeat (40000) @(posedge clk);
        fails++;
        wrap_up();
    end
endmodule
`default_nettype wire

// File: src/eeam_device.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - start, seven address bits, one direction bit
// - upper four type code, lower three select
// - select bits msb first equal reference register
// - copy stored code to reference after reset
// - master waits until the copy finishes
// - stored code starts zero, range zero to seven
// - direction bit low write, high read
// - any mismatch sends device to standby
// - type bits 7..4, select bits 3..1
// - lowest select bit sits at bit 1
module eeam_device #(
    parameter int LOAD_CYCLES = eeam_pkg::LOAD_CYC_D
) (
    input wire logic CE,
    input wire logic [7:0] MEM_CODE,
    output logic LOADED,
    output logic [2:0] REF_CODE,
    output logic CODE_ERR,
    output logic SELECTED,
    output logic READ_SEL,
    output logic MISMATCH,
    eeam_link_if.device bus
);
    import eeam_pkg::*;

    logic rst_s1, rst_s2;
    logic scl_s1, scl_s2, scl_p;
    logic sda_s1, sda_s2, sda_p;
    logic start_ev, stop_ev, rise_ev, fall_ev;

    eeam_dstate_t st_q, st_d;
    logic [16:0] ld_q, ld_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] sh_q, sh_d;
    logic [2:0] ref_q, ref_d;
    logic loaded_q, loaded_d;
    logic err_q, err_d;
    logic oe_q, oe_d;
    logic sel_q, sel_d;
    logic rd_q, rd_d;
    logic miss_q, miss_d;

    // all link pins and the link reset are resynchronised; the first stage feeds only the second
    always_ff @(posedge bus.link_clk) begin
        rst_s1 <= bus.link_rst;
        rst_s2 <= rst_s1;
        scl_s1 <= bus.scl;
        scl_s2 <= scl_s1;
        sda_s1 <= bus.sda;
        sda_s2 <= sda_s1;
    end

    always_ff @(posedge bus.link_clk) begin
        if (rst_s2) begin
            scl_p <= 1'b1;
            sda_p <= 1'b1;
        end else begin
            scl_p <= scl_s2;
            sda_p <= sda_s2;
        end
    end

    // start and stop are sda edges while scl stays high over both samples
    always_comb begin
        start_ev = scl_s2 && scl_p && sda_p && !sda_s2;
        stop_ev = scl_s2 && scl_p && !sda_p && sda_s2;
        rise_ev = scl_s2 && !scl_p;
        fall_ev = !scl_s2 && scl_p;
    end

    always_comb begin
        st_d = st_q;
        ld_d = ld_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        ref_d = ref_q;
        loaded_d = loaded_q;
        err_d = err_q;
        oe_d = oe_q;
        sel_d = sel_q;
        rd_d = rd_q;
        miss_d = 1'b0;
        if (st_q == D_LOAD) begin
            // the bus is not watched at all until the reference has been loaded from MEM_CODE, valid or not
            if (ld_q == 17'(LOAD_CYCLES)) begin
                ref_d = MEM_CODE[2:0];
                err_d = (MEM_CODE > CODE_MAX);
                loaded_d = 1'b1;
                st_d = D_IDLE;
            end else begin
                ld_d = ld_q + 17'h00001;
            end
        end else if (start_ev) begin
            st_d = D_ADDR;
            cnt_d = 4'h0;
            sh_d = 8'h00;
            oe_d = 1'b0;
            sel_d = 1'b0;
        end else if (stop_ev) begin
            st_d = D_IDLE;
            oe_d = 1'b0;
            sel_d = 1'b0;
        end else begin
            case (st_q)
                D_IDLE: begin
                    oe_d = 1'b0;
                end
                D_ADDR: begin
                    if (rise_ev && cnt_q != BYTE_LAST) begin
                        sh_d = {sh_q[6:0], sda_s2};
                        cnt_d = cnt_q + 4'h1;
                    end
                    if (fall_ev && cnt_q == BYTE_LAST) begin
                        if (eeam_addr_match(sh_q, ref_q)) begin
                            oe_d = 1'b1;
                            st_d = D_ACK;
                        end else begin
                            miss_d = 1'b1;
                            st_d = D_STBY;
                        end
                    end
                end
                D_ACK: begin
                    if (fall_ev) begin
                        oe_d = 1'b0;
                        sel_d = 1'b1;
                        rd_d = (sh_q[RW_POS] == RW_READ);
                        st_d = D_IDLE;
                    end
                end
                D_STBY: begin
                    oe_d = 1'b0;
                end
                default: begin
                    st_d = D_IDLE;
                    oe_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge bus.link_clk) begin
        if (rst_s2) begin
            st_q <= D_LOAD;
            ld_q <= 17'h00000;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            ref_q <= CODE_RESET;
            loaded_q <= 1'b0;
            err_q <= 1'b0;
            oe_q <= 1'b0;
            sel_q <= 1'b0;
            rd_q <= 1'b0;
            miss_q <= 1'b0;
        end else if (CE) begin
            st_q <= st_d;
            ld_q <= ld_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            ref_q <= ref_d;
            loaded_q <= loaded_d;
            err_q <= err_d;
            oe_q <= oe_d;
            sel_q <= sel_d;
            rd_q <= rd_d;
            miss_q <= miss_d;
        end
    end

    // ack is an open-drain pull-down only
    assign bus.sda_d_o = 1'b0;
    assign bus.sda_d_oe = oe_q;
    assign LOADED = loaded_q;
    assign REF_CODE = ref_q;
    assign CODE_ERR = err_q;
    assign SELECTED = sel_q;
    assign READ_SEL = rd_q;
    assign MISMATCH = miss_q;
endmodule
`default_nettype wire

// File: src/eeam_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface eeam_link_if;
    logic link_clk;
    logic link_rst;
    logic scl;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_d_o;
    logic sda_d_oe;
    logic sda;

    // open-drain wired-and with pull-up
    assign sda = !((sda_m_oe && !sda_m_o) || (sda_d_oe && !sda_d_o));

    modport master (
        output link_clk,
        output link_rst,
        output scl,
        output sda_m_o,
        output sda_m_oe,
        input sda
    );
    modport device (
        input link_clk,
        input link_rst,
        input scl,
        input sda,
        output sda_d_o,
        output sda_d_oe
    );
endinterface
`default_nettype wire

// File: src/eeam_master.sv
`timescale 1ns/1ps
`default_nettype none
module eeam_master #(
    parameter int LOAD_CYCLES = eeam_pkg::LOAD_CYC_M + eeam_pkg::LOAD_MARGIN
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic REQ,
    input wire logic [eeam_pkg::ADDR_BITS-1:0] ADDR,
    input wire logic RW,
    output logic READY,
    output logic DONE,
    output logic ACKED,
    eeam_link_if.master bus
);
    import eeam_pkg::*;

    eeam_mstate_t st_q, st_d;
    logic div_q, div_d;
    logic lrst_q, lrst_d;
    logic [4:0] lrc_q, lrc_d;
    logic [17:0] ld_q, ld_d;
    logic [3:0] tq_q, tq_d;
    logic [1:0] q_q, q_d;
    logic [2:0] bit_q, bit_d;
    logic [7:0] sh_q, sh_d;
    logic scl_q, scl_d;
    logic oe_q, oe_d;
    logic ready_q, ready_d;
    logic done_q, done_d;
    logic acked_q, acked_d;
    logic sda_s1, sda_s2;
    logic adv;

    function automatic logic [4:0] lrst_cnt_next(input logic [4:0] c);
        return (c == RST_HOLD) ? c : c + 5'h01;
    endfunction

    // link clock made by dividing CLK; the link reset is held past RST so the device sees clock edges under it
    always_comb begin
        div_d = ~div_q;
        lrc_d = lrst_cnt_next(lrc_q);
        lrst_d = (lrc_q != RST_HOLD);
        ld_d = ld_q;
        if (!lrst_q && ld_q != 18'(LOAD_CYCLES)) begin
            ld_d = ld_q + 18'h00001;
        end
    end

    always_comb begin
        st_d = st_q;
        tq_d = tq_q;
        q_d = q_q;
        bit_d = bit_q;
        sh_d = sh_q;
        scl_d = scl_q;
        oe_d = oe_q;
        done_d = 1'b0;
        acked_d = acked_q;
        adv = (tq_q == 4'(QUARTER_CYC - 1));
        if (st_q != M_IDLE) begin
            tq_d = adv ? 4'h0 : tq_q + 4'h1;
            if (adv) begin
                q_d = q_q + 2'h1;
                if (q_q == 2'h1) begin
                    scl_d = 1'b1;
                end
                if (q_q == Q_LAST && st_q != M_STOP) begin
                    scl_d = 1'b0;
                end
            end
        end
        case (st_q)
            M_IDLE: begin
                scl_d = 1'b1;
                oe_d = 1'b0;
                tq_d = 4'h0;
                q_d = 2'h0;
                if (REQ && ready_q) begin
                    sh_d = {ADDR, RW};
                    bit_d = 3'h0;
                    acked_d = 1'b0;
                    oe_d = 1'b1;
                    st_d = M_START;
                end
            end
            M_START: begin
                if (adv && q_q == Q_LAST) begin
                    st_d = M_BITS;
                end
            end
            M_BITS: begin
                if (adv && q_q == 2'h0) begin
                    oe_d = ~sh_q[7];
                end
                if (adv && q_q == Q_LAST) begin
                    sh_d = {sh_q[6:0], 1'b0};
                    bit_d = bit_q + 3'h1;
                    if (bit_q == BIT_LAST) begin
                        st_d = M_ACK;
                    end
                end
            end
            M_ACK: begin
                if (adv && q_q == 2'h0) begin
                    oe_d = 1'b0;
                end
                if (adv && q_q == Q_LAST) begin
                    acked_d = ~sda_s2;
                    st_d = M_STOP;
                end
            end
            M_STOP: begin
                if (adv && q_q == 2'h0) begin
                    oe_d = 1'b1;
                end
                if (adv && q_q == 2'h2) begin
                    oe_d = 1'b0;
                end
                if (adv && q_q == Q_LAST) begin
                    done_d = 1'b1;
                    st_d = M_IDLE;
                end
            end
            default: begin
                st_d = M_IDLE;
            end
        endcase
        ready_d = (st_d == M_IDLE) && (ld_d == 18'(LOAD_CYCLES));
    end

    always_ff @(posedge CLK) begin
        sda_s1 <= bus.sda;
        sda_s2 <= sda_s1;
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            div_q <= 1'b0;
            lrst_q <= 1'b1;
            lrc_q <= 5'h00;
            ld_q <= 18'h00000;
            st_q <= M_IDLE;
            tq_q <= 4'h0;
            q_q <= 2'h0;
            bit_q <= 3'h0;
            sh_q <= 8'h00;
            scl_q <= 1'b1;
            oe_q <= 1'b0;
            ready_q <= 1'b0;
            done_q <= 1'b0;
            acked_q <= 1'b0;
        end else if (CE) begin
            div_q <= div_d;
            lrst_q <= lrst_d;
            lrc_q <= lrc_d;
            ld_q <= ld_d;
            st_q <= st_d;
            tq_q <= tq_d;
            q_q <= q_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            scl_q <= scl_d;
            oe_q <= oe_d;
            ready_q <= ready_d;
            done_q <= done_d;
            acked_q <= acked_d;
        end
    end

    assign bus.link_clk = div_q;
    assign bus.link_rst = lrst_q;
    assign bus.scl = scl_q;
    assign bus.sda_m_o = 1'b0;
    assign bus.sda_m_oe = oe_q;
    assign READY = ready_q;
    assign DONE = done_q;
    assign ACKED = acked_q;
endmodule
`default_nettype wire

// File: src/eeam_pkg.sv
`default_nettype none
package eeam_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int LINK_DIV = 2;
    localparam int LINK_HZ = CLK_HZ / LINK_DIV;
    localparam int LOAD_TIME_MS = 10;
    // least time, so round up to whole cycles
    localparam int LOAD_CYC_M = (LOAD_TIME_MS * CLK_HZ + 999) / 1000;
    localparam int LOAD_CYC_D = (LOAD_TIME_MS * LINK_HZ + 999) / 1000;
    localparam int LOAD_MARGIN = 64;
    localparam int QUARTER_CYC = 8;
    localparam logic [4:0] RST_HOLD = 5'h10;
    localparam int ADDR_BITS = 7;
    localparam logic [3:0] BYTE_LAST = 4'h8;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [1:0] Q_LAST = 2'h3;
    localparam int TYPE_MSB = 7;
    localparam int TYPE_LSB = 4;
    localparam int SEL_MSB = 3;
    localparam int SEL_LSB = 1;
    localparam int RW_POS = 0;
    // arbitrary neutral value for the device-type code
    localparam logic [3:0] TYPE_CODE = 4'hC;
    localparam logic [2:0] CODE_RESET = 3'h0;
    localparam logic [7:0] CODE_MAX = 8'h07;
    localparam logic RW_WRITE = 1'b0;
    localparam logic RW_READ = 1'b1;

    typedef enum logic [2:0] {
        M_IDLE = 3'h0,
        M_START = 3'h1,
        M_BITS = 3'h3,
        M_ACK = 3'h2,
        M_STOP = 3'h6
    } eeam_mstate_t;

    typedef enum logic [2:0] {
        D_LOAD = 3'h0,
        D_IDLE = 3'h1,
        D_ADDR = 3'h3,
        D_ACK = 3'h2,
        D_STBY = 3'h6
    } eeam_dstate_t;

    function automatic logic eeam_addr_match(input logic [7:0] b, input logic [2:0] ref_code);
        return (b[TYPE_MSB:TYPE_LSB] == TYPE_CODE) && (b[SEL_MSB:SEL_LSB] == ref_code);
    endfunction
endpackage
`default_nettype wire
